// ===== rtl/cefr_event_flags.sv
`timescale 1ns/1ps
module cefr_event_flags (
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  input  wire cefr_pkg::cefr_events_t events,
  input  wire logic                 rd_en,
  input  wire logic [7:0]           rd_addr,
  output logic [7:0]                rd_data,
  output logic                      rd_hit
);
  // ==========================================================
  // Decode
  // One cell per event, timer cells in the low positions
  localparam int NUM_EVENTS = cefr_pkg::THERMAL_FIELDS + cefr_pkg::TIMER_FIELDS;

  logic                   rd_timer;
  logic                   rd_thermal;
  logic [NUM_EVENTS-1:0]  level_vec;
  logic [NUM_EVENTS-1:0]  edge_vec;
  logic [NUM_EVENTS-1:0]  clr_vec;
  logic [NUM_EVENTS-1:0]  flag_vec;
  cefr_pkg::cefr_events_t flag_s;
  logic [7:0]             rd_data_q;
  logic [7:0]             rd_data_d;

  // Read strobes per register
  always_comb begin
    rd_timer   = rd_en && (rd_addr == cefr_pkg::CHARGER_TIMER_EVENT_FLAGS_OFFSET);
    rd_thermal = rd_en && (rd_addr == cefr_pkg::THERMAL_AND_OTG_EVENT_FLAGS_OFFSET);
  end

  // Every event is edge detected; read of its register clears it
  assign level_vec = events;
  assign edge_vec  = '1;
  assign clr_vec   = {{cefr_pkg::THERMAL_FIELDS{rd_thermal}},
                      {cefr_pkg::TIMER_FIELDS{rd_timer}}};

  // Named view of the cells so the read mux cannot swap positions
  assign flag_s    = flag_vec;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_EVENTS; gi++) begin : g_cell
      cefr_flag_cell u_cell (
        .core_clk    (core_clk),
        .rstn        (rstn),
        .event_level (level_vec[gi]),
        .edge_mode   (edge_vec[gi]),
        .clear       (clr_vec[gi]),
        .flag        (flag_vec[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Read data, registered; reserved bits zero
  always_comb begin
    rd_data_d = cefr_pkg::FLAG_RESET_VALUE;
    if (rd_timer) begin
      rd_data_d[cefr_pkg::FINISH_TIMER_BIT]    = flag_s.finish_timer_expired_event;
      rd_data_d[cefr_pkg::PRECHARGE_TIMER_BIT] = flag_s.precharge_timer_expired_event;
    end else if (rd_thermal) begin
      rd_data_d[cefr_pkg::HOT_BIT]       = flag_s.battery_hot_crossing_event;
      rd_data_d[cefr_pkg::WARM_BIT]      = flag_s.battery_warm_crossing_event;
      rd_data_d[cefr_pkg::COOL_BIT]      = flag_s.battery_cool_crossing_event;
      rd_data_d[cefr_pkg::COLD_BIT]      = flag_s.battery_cold_crossing_event;
      rd_data_d[cefr_pkg::BOOST_LOW_BIT] = flag_s.battery_too_low_for_boost_event;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rd_data_q <= cefr_pkg::FLAG_RESET_VALUE;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

  assign rd_data = rd_data_q;
  assign rd_hit  = rd_timer | rd_thermal;

  // ==========================================================
  // Checks
  // Set checks: $rose stays quiet for an event already high at release
  property p_hot_set;
    @(posedge core_clk) disable iff (!rstn)
      (events.battery_hot_crossing_event && !$past(events.battery_hot_crossing_event))
      |=> flag_s.battery_hot_crossing_event;
  endproperty
  a_hot_set: assert property (p_hot_set) else $error("hot flag missed");

  property p_finish_set;
    @(posedge core_clk) disable iff (!rstn)
      $rose(events.finish_timer_expired_event) |=> flag_s.finish_timer_expired_event;
  endproperty
  a_finish_set: assert property (p_finish_set) else $error("finish flag missed");

  property p_pre_set;
    @(posedge core_clk) disable iff (!rstn)
      $rose(events.precharge_timer_expired_event) |=> flag_s.precharge_timer_expired_event;
  endproperty
  a_pre_set: assert property (p_pre_set) else $error("precharge flag missed");

  property p_boost_low_set;
    @(posedge core_clk) disable iff (!rstn)
      $rose(events.battery_too_low_for_boost_event)
      |=> flag_s.battery_too_low_for_boost_event;
  endproperty
  a_boost_low_set: assert property (p_boost_low_set) else $error("boost low flag missed");

  property p_cold_set;
    @(posedge core_clk) disable iff (!rstn)
      $rose(events.battery_cold_crossing_event) |=> flag_s.battery_cold_crossing_event;
  endproperty
  a_cold_set: assert property (p_cold_set) else $error("cold flag missed");

  property p_cool_set;
    @(posedge core_clk) disable iff (!rstn)
      $rose(events.battery_cool_crossing_event) |=> flag_s.battery_cool_crossing_event;
  endproperty
  a_cool_set: assert property (p_cool_set) else $error("cool flag missed");

  property p_warm_set;
    @(posedge core_clk) disable iff (!rstn)
      $rose(events.battery_warm_crossing_event) |=> flag_s.battery_warm_crossing_event;
  endproperty
  a_warm_set: assert property (p_warm_set) else $error("warm flag missed");

  // The warm flag may not rise without its event being high
  property p_warm_quiet;
    @(posedge core_clk) disable iff (!rstn)
      (!flag_s.battery_warm_crossing_event && !events.battery_warm_crossing_event)
      |=> !flag_s.battery_warm_crossing_event;
  endproperty
  a_warm_quiet: assert property (p_warm_quiet) else $error("warm flag set unprompted");

  // Register layout checks
  property p_reserved_zero;
    @(posedge core_clk) disable iff (!rstn) rd_data[7:5] == 3'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  property p_timer_upper_zero;
    @(posedge core_clk) disable iff (!rstn)
      rd_timer |=> (rd_data[cefr_pkg::FLAG_WIDTH-1:cefr_pkg::TIMER_FIELDS] == '0);
  endproperty
  a_timer_upper_zero: assert property (p_timer_upper_zero) else $error("timer upper bits set");

  property p_idle_zero;
    @(posedge core_clk) disable iff (!rstn)
      !rd_hit |=> (rd_data == cefr_pkg::FLAG_RESET_VALUE);
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("read data not zero when idle");

  // Read returns the flag held before the read edge
  property p_finish_read;
    @(posedge core_clk) disable iff (!rstn)
      (rd_timer && flag_s.finish_timer_expired_event)
      |=> rd_data[cefr_pkg::FINISH_TIMER_BIT];
  endproperty
  a_finish_read: assert property (p_finish_read) else $error("finish not read");

  property p_pre_read;
    @(posedge core_clk) disable iff (!rstn)
      (rd_timer && flag_s.precharge_timer_expired_event)
      |=> rd_data[cefr_pkg::PRECHARGE_TIMER_BIT];
  endproperty
  a_pre_read: assert property (p_pre_read) else $error("precharge not read");

  property p_read_returns;
    @(posedge core_clk) disable iff (!rstn)
      (rd_thermal && flag_s.battery_too_low_for_boost_event)
      |=> rd_data[cefr_pkg::BOOST_LOW_BIT];
  endproperty
  a_read_returns: assert property (p_read_returns) else $error("boost low not read");

  property p_cold_read;
    @(posedge core_clk) disable iff (!rstn)
      (rd_thermal && flag_s.battery_cold_crossing_event) |=> rd_data[cefr_pkg::COLD_BIT];
  endproperty
  a_cold_read: assert property (p_cold_read) else $error("cold not read");

  property p_cool_read;
    @(posedge core_clk) disable iff (!rstn)
      (rd_thermal && flag_s.battery_cool_crossing_event) |=> rd_data[cefr_pkg::COOL_BIT];
  endproperty
  a_cool_read: assert property (p_cool_read) else $error("cool not read");

  property p_cool_no_phantom;
    @(posedge core_clk) disable iff (!rstn)
      (rd_thermal && !flag_s.battery_cool_crossing_event) |=> !rd_data[cefr_pkg::COOL_BIT];
  endproperty
  a_cool_no_phantom: assert property (p_cool_no_phantom) else $error("cool read as set");

  property p_warm_read;
    @(posedge core_clk) disable iff (!rstn)
      (rd_thermal && flag_s.battery_warm_crossing_event) |=> rd_data[cefr_pkg::WARM_BIT];
  endproperty
  a_warm_read: assert property (p_warm_read) else $error("warm not read");

  property p_hot_read;
    @(posedge core_clk) disable iff (!rstn)
      (rd_thermal && flag_s.battery_hot_crossing_event) |=> rd_data[cefr_pkg::HOT_BIT];
  endproperty
  a_hot_read: assert property (p_hot_read) else $error("hot not read");

  // Flags hold until their own register is read
  property p_sticky;
    @(posedge core_clk) disable iff (!rstn)
      (flag_s.finish_timer_expired_event && !rd_timer) |=> flag_s.finish_timer_expired_event;
  endproperty
  a_sticky: assert property (p_sticky) else $error("finish flag dropped");

  property p_pre_sticky;
    @(posedge core_clk) disable iff (!rstn)
      (flag_s.precharge_timer_expired_event && !rd_timer)
      |=> flag_s.precharge_timer_expired_event;
  endproperty
  a_pre_sticky: assert property (p_pre_sticky) else $error("precharge flag dropped");

  property p_hot_sticky;
    @(posedge core_clk) disable iff (!rstn)
      (flag_s.battery_hot_crossing_event && !rd_thermal) |=> flag_s.battery_hot_crossing_event;
  endproperty
  a_hot_sticky: assert property (p_hot_sticky) else $error("hot flag dropped");

  // Read clears, but a fresh edge in the read cycle survives
  property p_read_clears;
    @(posedge core_clk) disable iff (!rstn)
      (rd_thermal && !events.battery_cold_crossing_event)
      |=> !flag_s.battery_cold_crossing_event;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("cold flag not cleared");

  property p_boost_clears;
    @(posedge core_clk) disable iff (!rstn)
      (rd_thermal && !events.battery_too_low_for_boost_event)
      |=> !flag_s.battery_too_low_for_boost_event;
  endproperty
  a_boost_clears: assert property (p_boost_clears) else $error("boost low not cleared");

  property p_timer_clears;
    @(posedge core_clk) disable iff (!rstn)
      (rd_timer && !events.precharge_timer_expired_event)
      |=> !flag_s.precharge_timer_expired_event;
  endproperty
  a_timer_clears: assert property (p_timer_clears) else $error("precharge not cleared");

  property p_set_beats_clear;
    @(posedge core_clk) disable iff (!rstn)
      (rd_thermal && $rose(events.battery_cool_crossing_event))
      |=> flag_s.battery_cool_crossing_event;
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear) else $error("clear beat new event");
endmodule : cefr_event_flags

// ===== rtl/cefr_flag_cell.sv
`timescale 1ns/1ps
// ==========================================================
// One sticky flag: rising edge sets, read clears, set wins
module cefr_flag_cell (
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic event_level,
  input  wire logic edge_mode,
  input  wire logic clear,
  output logic      flag
);
  logic last_q;
  logic last_d;
  logic flag_q;
  logic flag_d;
  logic hit;

  // Edge or level qualification of the detector output
  always_comb begin
    hit    = edge_mode ? (event_level & ~last_q) : event_level;
    last_d = event_level;
    flag_d = hit | (flag_q & ~clear);    // New event beats a read clear
  end

  // Registers only
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      last_q <= 1'h0;
      flag_q <= 1'h0;
    end else begin
      last_q <= last_d;
      flag_q <= flag_d;
    end
  end

  assign flag = flag_q;
endmodule : cefr_flag_cell

// ===== rtl/cefr_pkg.sv
package cefr_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] CHARGER_TIMER_EVENT_FLAGS_OFFSET   = 8'h24;
  localparam logic [7:0] THERMAL_AND_OTG_EVENT_FLAGS_OFFSET = 8'h25;
  localparam logic [7:0] FLAG_RESET_VALUE                   = 8'h00;
  localparam int         FLAG_WIDTH                         = 8;

  // ==========================================================
  // Field positions in the timer flag register
  localparam int FINISH_TIMER_BIT    = 0;
  localparam int PRECHARGE_TIMER_BIT = 1;

  // ==========================================================
  // Field positions in the thermal and boost flag register
  localparam int HOT_BIT        = 0;
  localparam int WARM_BIT       = 1;
  localparam int COOL_BIT       = 2;
  localparam int COLD_BIT       = 3;
  localparam int BOOST_LOW_BIT  = 4;
  localparam int THERMAL_FIELDS = 5;
  localparam int TIMER_FIELDS   = 2;

  // ==========================================================
  // Event inputs grouped together
  typedef struct packed {
    logic battery_too_low_for_boost_event;
    logic battery_cold_crossing_event;
    logic battery_cool_crossing_event;
    logic battery_warm_crossing_event;
    logic battery_hot_crossing_event;
    logic precharge_timer_expired_event;
    logic finish_timer_expired_event;
  } cefr_events_t;
endpackage : cefr_pkg

// ===== tb/cefr_event_flags_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
  $display("ERROR %0t: read bit mismatch got %h want %h", $time, a, b); end end
module cefr_event_flags_tb;
  // ==========================================================
  // Signals
  logic                   core_clk;
  logic                   rstn;
  logic                   rd_en;
  logic                   rd_hit;
  logic [7:0]             rd_addr;
  logic [7:0]             rd_data;
  logic [7:0]             exp_q;
  logic [6:0]             flg_q;
  logic [6:0]             prv_q;
  logic [6:0]             clr;
  logic [31:0]            r;
  logic [31:0]            seed = 32'he557_f7e5;
  cefr_pkg::cefr_events_t events;
  int                     failures = 0;
  int                     total_checks = 0;
  wire                    exp_hit = rd_en &&
    (rd_addr == cefr_pkg::CHARGER_TIMER_EVENT_FLAGS_OFFSET ||
     rd_addr == cefr_pkg::THERMAL_AND_OTG_EVENT_FLAGS_OFFSET);

  cefr_event_flags i_cefr_event_flags (
    .core_clk(core_clk), .rstn(rstn), .events(events), .rd_en(rd_en),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_hit(rd_hit));

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done

  // Clock, 20 ns period
  initial begin
    core_clk = 1'h0;
    forever #10 core_clk = ~core_clk;
  end

  // ==========================================================
  // Reference model: read returns old flags, fresh edge wins over clear
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      flg_q = '0;
      prv_q = '0;
      exp_q = '0;
    end else begin
      exp_q = 8'h00;
      clr   = 7'h00;
      if (rd_en && rd_addr == cefr_pkg::CHARGER_TIMER_EVENT_FLAGS_OFFSET) begin
        exp_q = {6'h00, flg_q[1:0]};
        clr   = 7'h03;
      end
      if (rd_en && rd_addr == cefr_pkg::THERMAL_AND_OTG_EVENT_FLAGS_OFFSET) begin
        exp_q = {3'h0, flg_q[6:2]};
        clr   = 7'h7c;
      end
      flg_q = (flg_q & ~clr) | (events & ~prv_q);
      prv_q = events;
    end
  end

  // Compare mid-cycle so registered outputs have settled
  always @(negedge core_clk) begin
    if (rstn) begin
      `CHK(rd_hit, exp_hit)
      `CHK(rd_data[0], exp_q[0])
      `CHK(rd_data[1], exp_q[1])
      `CHK(rd_data[2], exp_q[2])
      `CHK(rd_data[3], exp_q[3])
      `CHK(rd_data[4], exp_q[4])
      `CHK(rd_data[7:5], exp_q[7:5])
    end
  end

  // ==========================================================
  // Stimulus: slow event toggles so flags can be read, cleared, re-armed
  initial begin
    rstn    = 1'h0;
    rd_en   = 1'h0;
    rd_addr = 8'h00;
    events  = '0;
    repeat (10) @(posedge core_clk);
    rstn <= 1'h1;
    for (int i = 0; i < 4000; i++) begin
      @(posedge core_clk);
      r = xs();
      if (r[3:0] == 4'h0)
        events <= cefr_pkg::cefr_events_t'(events ^ (7'h01 << (r[10:8] % 7)));
      rd_en   <= r[5:4] != 2'h0;
      rd_addr <= (r[7:6] == 2'h0) ? r[31:24] : (r[6] ?
        cefr_pkg::THERMAL_AND_OTG_EVENT_FLAGS_OFFSET :
        cefr_pkg::CHARGER_TIMER_EVENT_FLAGS_OFFSET);
      // Mid-run reset with events possibly held high
      if (i == 2000) rstn <= 1'h0;
      if (i == 2004) rstn <= 1'h1;
    end
    test_done();
  end
endmodule : cefr_event_flags_tb
